/* rtl/cke_pkg.sv */
// Shared constants and types for the clock-enable power-state link
`default_nettype none
package cke_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_ACTIVE = 3'b001,
      ST_APD    = 3'b011,
      ST_PPD    = 3'b010,
      ST_SREF   = 3'b100
   } pwr_state_e;

   // Command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP  = 4'h7;
   localparam logic [3:0] CMD_DES  = 4'h8;
   localparam logic [3:0] CMD_MRS  = 4'h0;
   localparam logic [3:0] CMD_REF  = 4'h1;
   localparam logic [3:0] CMD_PRE  = 4'h2;
   localparam logic [3:0] CMD_ACT  = 4'h3;
   localparam logic [3:0] CMD_WR   = 4'h4;
   localparam logic [3:0] CMD_RD   = 4'h5;

   localparam int NUM_BANKS      = 8;
   localparam int CNT_W          = 10;
   // Host timing counts, in link clock periods
   localparam int MRD_NCK        = 4;
   localparam int MOD_NCK        = 12;
   localparam int CKE_MIN_NCK    = 3;
   localparam int XS_NCK         = 8;
   localparam int XSDLL_NCK      = 512;
   localparam int WR_AFTER_SRX   = 512;
   // Link clock divider: half period in core clocks (200 ns period at 25 ns)
   localparam int LINK_HALF_DIV  = 4;
   localparam int SYNC_STAGES    = 3;

endpackage
`default_nettype wire

/* rtl/cke_link_if.sv */
// Link between controller end and memory end: clock, clock enable, command
`timescale 1ns/1ps
`default_nettype none
interface cke_link_if;
   logic       mck;
   logic       cke;
   logic [3:0] cmd;
   logic [2:0] bank;
   logic       odt;

   modport ctrl (output mck, output cke, output cmd, output bank, output odt);
   modport mem  (input mck, input cke, input cmd, input bank, input odt);
endinterface
`default_nettype wire

/* rtl/cke_mem_end.sv */
// Memory end: power state decided from clock enable and command per link edge
//
// How it works
// R1 - Host waits mode-register delays before lowering CKE
// R2 - Action from CKE now, CKE before, command
// R3 - Current state is state before the edge
// R4 - Low-power with CKE low ignores all commands
// R5 - Host gives NOP/deselect on power-down edges
// R6 - Host gives NOP/deselect on self-refresh exit
// R7 - NOP with CKE fall, banks open: active PD
// R8 - Read/write/precharge fall: PD type by banks after
// R9 - NOP fall while refreshing or idle: precharge PD
// R10 - Self-refresh only by refresh from all idle
// R11 - No refresh performed while in power-down
// R12 - Host holds CKE for minimum pulse time
// R13 - Host sends NOP/deselect during exit delay
// R14 - Host: no read or termination before DLL delay
// R15 - Host: no write before 512 cycles
// R16 - Termination off in self-refresh, ignored for states
// R17 - Host avoids unlisted state and command sequences
// R18 - Idle means banks closed, CKE high, delays met
// R19 - Deselect behaves exactly like NOP
// R20 - Self-refresh exit seen without a link clock edge
// R21 - Explicit state register with five states
`timescale 1ns/1ps
`default_nettype none
module cke_mem_end
   import cke_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   cke_link_if.mem         link,
   output logic [2:0]      pwr_state,
   output logic [NUM_BANKS-1:0] open_banks,
   output logic            odt_active,
   output logic            refresh_pulse,
   output logic            illegal_seen
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_STAGES-1:0] mck_sync_ff;
   logic [SYNC_STAGES-1:0] cke_sync_ff;
   logic [SYNC_STAGES-1:0] odt_sync_ff;
   logic                   mck_lvl_ff;
   logic                   cke_lvl_ff;
   logic                   odt_lvl_ff;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mck_sync_ff <= '0;
         cke_sync_ff <= '0;
         odt_sync_ff <= '0;
      end
      else
      begin
         mck_sync_ff <= {mck_sync_ff[1:0], link.mck};
         cke_sync_ff <= {cke_sync_ff[1:0], link.cke};
         odt_sync_ff <= {odt_sync_ff[1:0], link.odt};
      end
   end

   // A level counts once stages two and three agree
   wire mck_agree = (mck_sync_ff[1] == mck_sync_ff[2]);
   wire cke_agree = (cke_sync_ff[1] == cke_sync_ff[2]);
   wire odt_agree = (odt_sync_ff[1] == odt_sync_ff[2]);

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mck_lvl_ff <= 1'b0;
         cke_lvl_ff <= 1'b0;
         odt_lvl_ff <= 1'b0;
      end
      else
      begin
         if (mck_agree) mck_lvl_ff <= mck_sync_ff[2];
         if (cke_agree) cke_lvl_ff <= cke_sync_ff[2];
         if (odt_agree) odt_lvl_ff <= odt_sync_ff[2];
      end
   end

   // Command and bank pass the same three stages and are taken once stages two and
   // three agree; the host holds them a whole link period, so they settle in time
   logic [SYNC_STAGES-1:0][6:0] cab_sync_ff;
   logic [3:0]                  cmd_smp_ff;
   logic [2:0]                  bank_smp_ff;
   wire                         cab_agree = (cab_sync_ff[1] == cab_sync_ff[2]);

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cab_sync_ff <= {SYNC_STAGES{3'h0, CMD_DES}};
         cmd_smp_ff  <= CMD_DES;
         bank_smp_ff <= 3'h0;
      end
      else
      begin
         cab_sync_ff <= {cab_sync_ff[1:0], link.bank, link.cmd};
         if (cab_agree)
         begin
            cmd_smp_ff  <= cab_sync_ff[2][3:0];
            bank_smp_ff <= cab_sync_ff[2][6:4];
         end
      end
   end

   wire mck_rise = mck_agree && mck_sync_ff[2] && !mck_lvl_ff;

   // ----------------------------------------------------------------
   // Edge evaluation
   // ----------------------------------------------------------------
   pwr_state_e        state_ff;
   pwr_state_e        nxt_state;
   logic              cke_prev_ff;
   logic [NUM_BANKS-1:0] nxt_open;
   logic              ref_busy_ff;
   logic              nxt_illegal;

   // R2: evaluated with CKE at edge N and N-1
   wire cke_now  = cke_lvl_ff;
   wire cke_fall = cke_prev_ff && !cke_now; // R2
   wire cke_rise = !cke_prev_ff && cke_now; // R2
   // Deselect decodes as NOP whatever the other lines do
   wire is_nop   = cmd_smp_ff[3] || (cmd_smp_ff == CMD_NOP); // R19
   wire is_rdwr  = (cmd_smp_ff == CMD_RD) || (cmd_smp_ff == CMD_WR);
   wire is_pre   = (cmd_smp_ff == CMD_PRE);
   wire is_act   = (cmd_smp_ff == CMD_ACT);
   wire is_ref   = (cmd_smp_ff == CMD_REF);
   wire [NUM_BANKS-1:0] bank_bit = NUM_BANKS'(1) << bank_smp_ff;
   // Precharge closes the addressed bank; read/write leave banks as they are
   wire [NUM_BANKS-1:0] banks_after = is_pre ? (open_banks & ~bank_bit) :
                                      is_act ? (open_banks | bank_bit) : open_banks;
   // Self-refresh exit: CKE high while in self-refresh, no link edge needed
   wire sref_exit = (state_ff == ST_SREF) && cke_now; // R20

   always_comb
   begin
      nxt_state   = state_ff; // R3
      nxt_open    = open_banks;
      nxt_illegal = 1'b0;
      case (state_ff)
         ST_PPD, ST_APD:
         begin
            // R4: CKE low keeps the state and ignores command lines
            if (cke_rise)
            begin
               if (!is_nop)
                  nxt_illegal = 1'b1;
               nxt_state = (state_ff == ST_APD) ? ST_ACTIVE : ST_IDLE;
            end
         end
         ST_SREF:
         begin
            nxt_state = ST_SREF; // R4
         end
         ST_IDLE:
         begin
            if (cke_fall && is_ref)
               nxt_state = ST_SREF; // R10
            else if (cke_fall && is_nop)
               nxt_state = ST_PPD; // R9
            else if (cke_fall)
               nxt_illegal = 1'b1;
            else if (is_act)
            begin
               nxt_open  = banks_after;
               nxt_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE:
         begin
            nxt_open = banks_after;
            if (cke_fall && (is_nop || is_rdwr || is_pre))
               nxt_state = (banks_after == '0) ? ST_PPD : ST_APD; // R7 R8
            else if (cke_fall)
               nxt_illegal = 1'b1; // R10
            else if (banks_after == '0)
               nxt_state = ST_IDLE; // R18
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff    <= ST_IDLE;
         open_banks  <= '0;
         cke_prev_ff <= 1'b0;
         ref_busy_ff <= 1'b0;
         illegal_seen <= 1'b0;
      end
      else if (sref_exit)
         state_ff <= ST_IDLE; // R20 R21
      else if (mck_rise)
      begin
         state_ff     <= nxt_state; // R21
         open_banks   <= nxt_open;
         cke_prev_ff  <= cke_now;
         ref_busy_ff  <= (state_ff == ST_IDLE) && cke_now && is_ref;
         illegal_seen <= illegal_seen | nxt_illegal;
      end
   end

   // Refresh only runs from an idle, clock-enabled state; none in power-down
   assign refresh_pulse = mck_rise && ref_busy_ff &&
                          (state_ff != ST_PPD) && (state_ff != ST_APD); // R11
   // Termination follows its pin but never in self-refresh
   assign odt_active = odt_lvl_ff && (state_ff != ST_SREF); // R16
   assign pwr_state  = state_ff;

endmodule
`default_nettype wire

/* rtl/cke_ctrl_end.sv */
// Controller end: drives link clock, clock enable and commands with guard timing
`timescale 1ns/1ps
`default_nettype none
module cke_ctrl_end
   import cke_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   cke_link_if.ctrl        link,
   input  wire logic       req_valid,
   input  wire logic [3:0] req_cmd,
   input  wire logic [2:0] req_bank,
   input  wire logic       req_cke,
   input  wire logic       req_odt,
   output logic            req_ready,
   output logic            in_sref
);

   // ----------------------------------------------------------------
   // Link clock divider
   // ----------------------------------------------------------------
   logic [3:0] div_ff;
   logic       mck_ff;
   wire        div_end = (div_ff == 4'(LINK_HALF_DIV - 1));
   wire        edge_out = div_end && mck_ff;  // next core edge starts low phase

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_ff <= '0;
         mck_ff <= 1'b0;
      end
      else
      begin
         div_ff <= div_end ? 4'h0 : div_ff + 4'h1;
         if (div_end)
            mck_ff <= !mck_ff;
      end
   end

   // ----------------------------------------------------------------
   // Guard counters, in link cycles
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] mod_cnt_ff;
   logic [CNT_W-1:0] cke_cnt_ff;
   logic [CNT_W-1:0] srx_cnt_ff;
   logic             cke_ff;
   logic             sref_ff;
   logic             odt_ff;
   logic [3:0]       cmd_ff;
   logic [2:0]       bank_ff;
   logic [NUM_BANKS-1:0] open_ff;

   wire [NUM_BANKS-1:0] req_bank_bit = NUM_BANKS'(1) << req_bank;
   // Self-refresh entry needs every bank closed and no burst just launched
   wire burst_or_open = (open_ff != '0) || (cmd_ff == CMD_RD) || (cmd_ff == CMD_WR);

   wire want_fall = cke_ff && !req_cke;
   wire want_rise = !cke_ff && req_cke;
   wire is_nop    = req_cmd[3] || (req_cmd == CMD_NOP);
   wire is_rd     = (req_cmd == CMD_RD);
   wire is_wr     = (req_cmd == CMD_WR);
   wire srx_busy  = srx_cnt_ff != '0;
   wire srx_age_lt_xs    = srx_busy && (srx_cnt_ff > CNT_W'(WR_AFTER_SRX - XS_NCK));
   wire srx_age_lt_dll   = srx_busy && (srx_cnt_ff > CNT_W'(WR_AFTER_SRX - XSDLL_NCK));

   assign req_ready =
      edge_out &&
      !(want_fall && mod_cnt_ff != '0) &&                      // R1
      !((want_fall || want_rise) && cke_cnt_ff != '0) &&       // R12
      !((want_fall || want_rise) && !is_nop &&
        !(want_fall && req_cmd == CMD_REF)) &&                 // R5 R6
      !(want_fall && req_cmd == CMD_REF && burst_or_open) &&   // R10
      !(srx_age_lt_xs && !is_nop) &&                           // R13
      !(srx_age_lt_dll && (is_rd || req_odt)) &&               // R14
      !(srx_busy && is_wr) &&                                  // R15
      !(!cke_ff && !req_cke && !is_nop);                       // R17

   wire take = req_valid && req_ready;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cke_ff  <= 1'b0;
         sref_ff <= 1'b0;
         odt_ff  <= 1'b0;
         cmd_ff  <= CMD_DES;
         bank_ff <= '0;
         open_ff <= '0;
      end
      else if (edge_out)
      begin
         cmd_ff <= take ? req_cmd : CMD_DES;
         if (take)
         begin
            cke_ff  <= req_cke;
            odt_ff  <= req_odt && !(want_fall && req_cmd == CMD_REF);
            bank_ff <= req_bank;
            if (req_cmd == CMD_ACT)
               open_ff <= open_ff | req_bank_bit;
            else if (req_cmd == CMD_PRE)
               open_ff <= open_ff & ~req_bank_bit;
            if (want_fall && req_cmd == CMD_REF)
               sref_ff <= 1'b1;
            else if (want_rise)
               sref_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mod_cnt_ff <= '0;
         cke_cnt_ff <= '0;
         srx_cnt_ff <= '0;
      end
      else if (edge_out)
      begin
         if (take && req_cmd == CMD_MRS)
            mod_cnt_ff <= CNT_W'(MOD_NCK > MRD_NCK ? MOD_NCK : MRD_NCK); // R1
         else if (mod_cnt_ff != '0)
            mod_cnt_ff <= mod_cnt_ff - 1'b1;
         if (take && req_cke != cke_ff)
            cke_cnt_ff <= CNT_W'(CKE_MIN_NCK - 1); // R12
         else if (cke_cnt_ff != '0)
            cke_cnt_ff <= cke_cnt_ff - 1'b1;
         if (take && want_rise && sref_ff)
            srx_cnt_ff <= CNT_W'(WR_AFTER_SRX); // R15
         else if (srx_cnt_ff != '0)
            srx_cnt_ff <= srx_cnt_ff - 1'b1;
      end
   end

   assign link.mck  = mck_ff;
   assign link.cke  = cke_ff;
   assign link.cmd  = cmd_ff;
   assign link.bank = bank_ff;
   assign link.odt  = odt_ff;
   assign in_sref   = sref_ff;

endmodule
`default_nettype wire

/* dv/cke_link_assertions.sv */
// Concurrent checks on the link between the controller end and the memory end
`timescale 1ns/1ps
`default_nettype none
module cke_link_assertions
   import cke_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       arst_n,
   input wire logic       mck,
   input wire logic       cke,
   input wire logic [3:0] cmd,
   input wire logic [2:0] bank,
   input wire logic       odt
);
   // ----------------------------------------
   // Link edge tracking
   // ----------------------------------------
   logic       mck_d_ff;
   logic       cke_prev_ff;
   logic       sref_ff;
   logic [3:0] tog_cnt_ff;
   logic [3:0] mrs_cnt_ff;
   logic [9:0] srx_cnt_ff;
   wire        link_edge = mck && !mck_d_ff;
   wire        quiet_cmd = (cmd == CMD_NOP) || cmd[3];
   wire        cke_tog   = link_edge && (cke != cke_prev_ff);
   wire        cke_fall  = link_edge && cke_prev_ff && !cke;
   wire        srx_edge  = link_edge && !cke_prev_ff && cke && sref_ff;
   // Counters saturate so a long idle run never wraps into a false window
   wire [3:0]  nxt_tog   = cke_tog ? 4'h0 : ((tog_cnt_ff == 4'hf) ? 4'hf : tog_cnt_ff + 4'h1);
   wire [3:0]  nxt_mrs   = (cmd == CMD_MRS) ? 4'h0
                                            : ((mrs_cnt_ff == 4'hf) ? 4'hf : mrs_cnt_ff + 4'h1);
   wire [9:0]  nxt_srx   = srx_edge ? 10'h0
                                    : ((srx_cnt_ff == 10'h3ff) ? 10'h3ff : srx_cnt_ff + 10'h1);
   wire        nxt_sref  = (cke_fall && cmd == CMD_REF) ? 1'b1 : (srx_edge ? 1'b0 : sref_ff);

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mck_d_ff    <= 1'b0;
         cke_prev_ff <= 1'b0;
         sref_ff     <= 1'b0;
         tog_cnt_ff  <= 4'hf;
         mrs_cnt_ff  <= 4'hf;
         srx_cnt_ff  <= 10'h3ff;
      end
      else
      begin
         mck_d_ff <= mck;
         if (link_edge)
         begin
            cke_prev_ff <= cke;
            sref_ff     <= nxt_sref;
            tog_cnt_ff  <= nxt_tog;
            mrs_cnt_ff  <= nxt_mrs;
            srx_cnt_ff  <= nxt_srx;
         end
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence link_high_s;
      mck [*4];
   endsequence
   sequence link_low_s;
      !mck [*4];
   endsequence

   clk_divide_a: assert property ($rose(mck) |-> link_high_s ##1 link_low_s ##1 mck)
      else $error("link clock period is not eight core cycles");
   link_stable_a: assert property (($changed(cke) || $changed(cmd) || $changed(odt)
      || $changed(bank)) |-> $fell(mck))
      else $error("link signals changed away from the falling link edge");
   pd_edge_quiet_a: assert property (cke_tog |-> quiet_cmd || (!cke && cmd == CMD_REF))
      else $error("command other than nop or deselect on a clock enable change");
   cke_hold_a: assert property (cke_tog |-> tog_cnt_ff >= 4'(CKE_MIN_NCK - 2))
      else $error("clock enable toggled before its minimum pulse time");
   mrs_gap_a: assert property (cke_fall |-> mrs_cnt_ff >= 4'(MOD_NCK - 1))
      else $error("clock enable dropped inside the mode register delay");
   lowpwr_quiet_a: assert property ((link_edge && !cke && !cke_prev_ff) |-> quiet_cmd)
      else $error("command issued while clock enable stays low");
   srx_nop_a: assert property ((link_edge && srx_cnt_ff < 10'(XS_NCK - 1)) |-> quiet_cmd)
      else $error("command issued inside the self-refresh exit delay");
   srx_dll_a: assert property ((link_edge && srx_cnt_ff < 10'(XSDLL_NCK - 1))
      |-> cmd != CMD_RD && cmd != CMD_WR && !odt)
      else $error("read, write or termination inside the lock delay");
endmodule
`default_nettype wire

/* dv/cke_power_state_control_tb.sv */
// Self-checking bench joining the controller end and the memory end over the link
`timescale 1ns/1ps
`default_nettype none
module cke_power_state_control_tb
   import cke_pkg::*;
;
   logic                 core_clk      = 1'b0;
   logic                 arst_n        = 1'b0;
   logic                 req_valid     = 1'b0;
   logic [3:0]           req_cmd       = CMD_DES;
   logic [2:0]           req_bank      = 3'h0;
   logic                 req_cke       = 1'b0;
   logic                 req_odt       = 1'b0;
   logic                 req_ready;
   logic                 in_sref;
   logic [2:0]           pwr_state;
   logic [NUM_BANKS-1:0] open_banks;
   logic                 odt_active;
   logic                 refresh_pulse;
   logic                 illegal_seen;
   int                   n_fail        = 0;
   int                   cmp_count     = 0;
   int                   n_ref         = 0;

   always #12.5 core_clk = ~core_clk;

   cke_link_if cke_link_if_inst ();
   cke_ctrl_end cke_ctrl_end_inst (.core_clk(core_clk), .arst_n(arst_n), .link(cke_link_if_inst),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_cke(req_cke),
      .req_odt(req_odt), .req_ready(req_ready), .in_sref(in_sref));
   cke_mem_end cke_mem_end_inst (.core_clk(core_clk), .arst_n(arst_n), .link(cke_link_if_inst),
      .pwr_state(pwr_state), .open_banks(open_banks), .odt_active(odt_active),
      .refresh_pulse(refresh_pulse), .illegal_seen(illegal_seen));
   cke_link_assertions cke_link_assertions_inst (.core_clk(core_clk), .arst_n(arst_n),
      .mck(cke_link_if_inst.mck), .cke(cke_link_if_inst.cke), .cmd(cke_link_if_inst.cmd),
      .bank(cke_link_if_inst.bank), .odt(cke_link_if_inst.odt));

   // Refresh must never be performed while powered down
   always @(negedge core_clk)
      if (refresh_pulse === 1'b1)
      begin
         n_ref++;
         if (pwr_state === ST_APD || pwr_state === ST_PPD)
            chk("refresh in power-down", 8'h01, 8'h00);
      end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic st(input pwr_state_e e);
      chk("pwr_state", {5'h0, pwr_state}, {5'h0, e});
   endtask

   // Holds the request until taken, then leaves time for the memory end to sample it
   task automatic send(input logic [3:0] c, input logic [2:0] b, input logic k);
      int i;
      req_cmd   = c;
      req_bank  = b;
      req_cke   = k;
      req_valid = 1'b1;
      #1;
      for (i = 0; i < 400 && req_ready !== 1'b1; i++)
      begin
         @(posedge core_clk);
         #2;
      end
      if (i == 400)
      begin
         n_fail++;
         end_of_test();
      end
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
      repeat (16) @(posedge core_clk);
      #1;
   endtask

   // A refused request must see no ready for three link periods
   task automatic refused(input string what, input logic [3:0] c, input logic k);
      int hits;
      hits      = 0;
      req_cmd   = c;
      req_cke   = k;
      req_valid = 1'b1;
      repeat (24)
      begin
         #1;
         if (req_ready === 1'b1)
            hits++;
         @(posedge core_clk);
         #1;
      end
      req_valid = 1'b0;
      chk(what, 8'(hits), 8'h00);
      @(posedge core_clk);
      #1;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      st(ST_IDLE);
      chk("reset cmd", {4'h0, cke_link_if_inst.cmd}, {4'h0, CMD_DES});
      send(CMD_NOP, 3'h0, 1'b1);
      st(ST_IDLE);
      send(CMD_ACT, 3'h2, 1'b1);
      st(ST_ACTIVE);
      chk("open_banks", open_banks, 8'h04);
      refused("self-refresh with bank open", CMD_REF, 1'b0);
      send(CMD_NOP, 3'h0, 1'b0);
      st(ST_APD);
      refused("read in power-down", CMD_RD, 1'b0);
      st(ST_APD);
      send(CMD_DES, 3'h0, 1'b1);
      st(ST_ACTIVE);
      $display("active power-down test done");
      send(CMD_PRE, 3'h2, 1'b1);
      st(ST_IDLE);
      chk("open_banks", open_banks, 8'h00);
      send(CMD_NOP, 3'h0, 1'b0);
      st(ST_PPD);
      send(CMD_NOP, 3'h0, 1'b1);
      st(ST_IDLE);
      send(CMD_MRS, 3'h0, 1'b1);
      refused("early enable drop", CMD_NOP, 1'b0);
      send(CMD_NOP, 3'h0, 1'b0);
      st(ST_PPD);
      send(CMD_NOP, 3'h0, 1'b1);
      $display("precharge power-down test done");
      send(CMD_REF, 3'h0, 1'b0);
      st(ST_SREF);
      chk("in_sref", {7'h0, in_sref}, 8'h01);
      chk("odt_active", {7'h0, odt_active}, 8'h00);
      req_odt = 1'b1;
      send(CMD_NOP, 3'h0, 1'b0);
      chk("odt_active in self-refresh", {7'h0, odt_active}, 8'h00);
      req_odt = 1'b0;
      send(CMD_NOP, 3'h0, 1'b1);
      st(ST_IDLE);
      refused("activate in exit delay", CMD_ACT, 1'b1);
      refused("read in lock delay", CMD_RD, 1'b1);
      refused("write in lock delay", CMD_WR, 1'b1);
      send(CMD_REF, 3'h0, 1'b1);
      chk("refresh pulses", 8'(n_ref), 8'h01);
      chk("illegal_seen", {7'h0, illegal_seen}, 8'h00);
      $display("self-refresh test done");
      end_of_test();
   end
endmodule
`default_nettype wire
